// ==== pkg/sacc_pkg.sv ====
// constants and types for the converter control block
package sacc_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] RES_OFS = 8'h08;
  localparam logic [7:0] AUX_OFS = 8'h0C;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_TM_BIT = 6;
  localparam int CTRL_INT_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_WINT_BIT = 3;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_LJ_BIT = 2;
  localparam int AUX_IE_BIT = 0;
  localparam int AUX_DIFF_BIT = 1;
  localparam int AUX_T2W_BIT = 2;
  localparam int AUX_T3W_BIT = 3;
  localparam logic [4:0] DIV_RST = 5'h1F;
  localparam logic [1:0] TRACK_CLKS = 2'h3;
  localparam logic [3:0] SAR_CLKS = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SRC_SW = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_T2 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_PIN = 3'h4;
  localparam logic [2:0] SRC_T3 = 3'h5;
  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sacc_state_t;
endpackage

// ==== src/sacc_top.sv ====
// conversion control with axi4-lite register access
`timescale 1ns/10ps
module sacc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger sources
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic tmr2_low_ovf,
  input wire logic tmr2_high_ovf,
  input wire logic tmr3_low_ovf,
  input wire logic tmr3_high_ovf,
  input wire logic external_start_pin,
  input wire logic standby_req,
  // sar core handshake
  input wire logic [9:0] sar_code,
  output logic sar_clk_pulse,
  output logic track_en,
  output logic sar_convert,
  output logic sar_sample,
  output logic conv_irq
);
  typedef struct packed {
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic conv_enable, tracking_mode_select, conv_complete_flag;
    logic window_compare_flag;
    logic [2:0] start_source_select;
    logic [4:0] conv_clock_divider;
    logic justify_select;
    logic irq_en, diff_mode, t2_wide, t3_wide;
    logic [7:0] result_high_byte, result_low_byte;
    logic [4:0] div_cnt;
    logic [3:0] step;
    sacc_pkg::sacc_state_t st;
    logic pin_s1, pin_s2, pin_d;
    logic sample, irq;
  } sacc_reg_t;

  sacc_reg_t r_ff, nxt_r;
  logic tick, pin_rise, trig, wr_fire, sw_start, conv_done;
  logic [9:0] code;
  logic [15:0] res_word;
  logic [31:0] ctrl_rd, cfg_rd, aux_rd;

  assign tick = (r_ff.div_cnt == r_ff.conv_clock_divider);
  assign pin_rise = r_ff.pin_s2 & ~r_ff.pin_d;
  assign wr_fire = r_ff.aw_got & r_ff.w_got & ~r_ff.bvalid;
  assign sw_start = wr_fire && r_ff.aw_addr == sacc_pkg::CTRL_OFS
    && r_ff.wstrb[0] && r_ff.wdata[sacc_pkg::CTRL_BUSY_BIT]
    && r_ff.start_source_select == sacc_pkg::SRC_SW;
  assign conv_done = (r_ff.st == sacc_pkg::ST_CONV) && tick
    && (r_ff.step == sacc_pkg::SAR_CLKS - 4'h1);
  assign code = sar_code;

  // start source mux
  always_comb
  begin
    unique case (r_ff.start_source_select)
      sacc_pkg::SRC_SW: trig = sw_start;
      sacc_pkg::SRC_T0: trig = tmr0_ovf;
      sacc_pkg::SRC_T2: trig = r_ff.t2_wide ? tmr2_high_ovf : tmr2_low_ovf;
      sacc_pkg::SRC_T1: trig = tmr1_ovf;
      sacc_pkg::SRC_PIN: trig = pin_rise;
      sacc_pkg::SRC_T3: trig = r_ff.t3_wide ? tmr3_high_ovf : tmr3_low_ovf;
      default: trig = 1'b0;
    endcase
  end

  // result formatting
  always_comb
  begin
    if (r_ff.justify_select)
      res_word = {code, 6'h00};
    else if (r_ff.diff_mode)
      res_word = {{6{code[9]}}, code};
    else
      res_word = {6'h00, code};
  end

  assign ctrl_rd = {24'h000000, r_ff.conv_enable, r_ff.tracking_mode_select,
    r_ff.conv_complete_flag, r_ff.st != sacc_pkg::ST_IDLE,
    r_ff.window_compare_flag, r_ff.start_source_select};
  assign cfg_rd = {24'h000000, r_ff.conv_clock_divider, r_ff.justify_select,
    2'h0};
  assign aux_rd = {28'h0000000, r_ff.t3_wide, r_ff.t2_wide, r_ff.diff_mode,
    r_ff.irq_en};

  always_comb
  begin
    nxt_r = r_ff;
    // pin synchroniser and edge detect
    nxt_r.pin_s1 = external_start_pin;
    nxt_r.pin_s2 = r_ff.pin_s1;
    nxt_r.pin_d = r_ff.pin_s2;
    nxt_r.sample = 1'b0;
    nxt_r.div_cnt = tick ? 5'h00 : r_ff.div_cnt + 5'h01;
    // axi write capture
    if (s_axi_awvalid && !r_ff.aw_got)
    begin
      nxt_r.aw_got = 1'b1;
      nxt_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_ff.w_got)
    begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = s_axi_wdata;
      nxt_r.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = sacc_pkg::RESP_OKAY;
      if (r_ff.wstrb[0])
        unique case (r_ff.aw_addr)
          sacc_pkg::CTRL_OFS:
          begin
            nxt_r.conv_enable = r_ff.wdata[sacc_pkg::CTRL_EN_BIT];
            nxt_r.tracking_mode_select = r_ff.wdata[sacc_pkg::CTRL_TM_BIT];
            // clear only by writing 0
            if (!r_ff.wdata[sacc_pkg::CTRL_INT_BIT])
              nxt_r.conv_complete_flag = 1'b0;
            nxt_r.window_compare_flag = r_ff.wdata[sacc_pkg::CTRL_WINT_BIT];
            nxt_r.start_source_select = r_ff.wdata[2:0];
          end
          sacc_pkg::CFG_OFS:
          begin
            nxt_r.conv_clock_divider = r_ff.wdata[7:3];
            nxt_r.justify_select = r_ff.wdata[sacc_pkg::CFG_LJ_BIT];
          end
          sacc_pkg::RES_OFS:
          begin
            nxt_r.result_low_byte = r_ff.wdata[7:0];
            if (r_ff.wstrb[1])
              nxt_r.result_high_byte = r_ff.wdata[15:8];
          end
          sacc_pkg::AUX_OFS:
          begin
            nxt_r.irq_en = r_ff.wdata[sacc_pkg::AUX_IE_BIT];
            nxt_r.diff_mode = r_ff.wdata[sacc_pkg::AUX_DIFF_BIT];
            nxt_r.t2_wide = r_ff.wdata[sacc_pkg::AUX_T2W_BIT];
            nxt_r.t3_wide = r_ff.wdata[sacc_pkg::AUX_T3W_BIT];
          end
          default: nxt_r.bresp = sacc_pkg::RESP_SLVERR;
        endcase
      else if (r_ff.aw_addr != sacc_pkg::CTRL_OFS
        && r_ff.aw_addr != sacc_pkg::CFG_OFS
        && r_ff.aw_addr != sacc_pkg::RES_OFS
        && r_ff.aw_addr != sacc_pkg::AUX_OFS)
        nxt_r.bresp = sacc_pkg::RESP_SLVERR;
    end
    if (r_ff.bvalid && s_axi_bready)
    begin
      nxt_r.bvalid = 1'b0;
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
    end
    // axi read
    if (s_axi_arvalid && !r_ff.rvalid)
    begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = sacc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sacc_pkg::CTRL_OFS: nxt_r.rdata = ctrl_rd;
        sacc_pkg::CFG_OFS: nxt_r.rdata = cfg_rd;
        sacc_pkg::RES_OFS: nxt_r.rdata = {16'h0000, r_ff.result_high_byte,
          r_ff.result_low_byte};
        sacc_pkg::AUX_OFS: nxt_r.rdata = aux_rd;
        default:
        begin
          nxt_r.rdata = 32'h00000000;
          nxt_r.rresp = sacc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (r_ff.rvalid && s_axi_rready)
      nxt_r.rvalid = 1'b0;
    // conversion sequencer
    unique case (r_ff.st)
      // triggers only seen in idle
      sacc_pkg::ST_IDLE:
        if (r_ff.conv_enable && trig)
        begin
          nxt_r.step = 4'h0;
          nxt_r.st = r_ff.tracking_mode_select ? sacc_pkg::ST_TRACK
            : sacc_pkg::ST_CONV;
          nxt_r.sample = ~r_ff.tracking_mode_select;
        end
      sacc_pkg::ST_TRACK:
        if (tick)
        begin
          if (r_ff.step == {2'h0, sacc_pkg::TRACK_CLKS} - 4'h1)
          begin
            nxt_r.step = 4'h0;
            nxt_r.st = sacc_pkg::ST_CONV;
            nxt_r.sample = 1'b1;
          end
          else
            nxt_r.step = r_ff.step + 4'h1;
        end
      sacc_pkg::ST_CONV:
        if (conv_done)
        begin
          nxt_r.st = sacc_pkg::ST_IDLE;
          nxt_r.conv_complete_flag = 1'b1;
          nxt_r.result_high_byte = res_word[15:8];
          nxt_r.result_low_byte = res_word[7:0];
        end
        else if (tick)
          nxt_r.step = r_ff.step + 4'h1;
    endcase
    // interrupt level follows the complete flag while irq_en is set
    nxt_r.irq = r_ff.irq_en & nxt_r.conv_complete_flag;
    // disable aborts conversion
    if (!r_ff.conv_enable)
      nxt_r.st = sacc_pkg::ST_IDLE;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      r_ff <= '0;
      r_ff.conv_clock_divider <= sacc_pkg::DIV_RST;
    end
    else
      r_ff <= nxt_r;
  end

  assign s_axi_awready = ~r_ff.aw_got;
  assign s_axi_wready = ~r_ff.w_got;
  assign s_axi_bvalid = r_ff.bvalid;
  assign s_axi_bresp = r_ff.bresp;
  assign s_axi_arready = ~r_ff.rvalid;
  assign s_axi_rvalid = r_ff.rvalid;
  assign s_axi_rdata = r_ff.rdata;
  assign s_axi_rresp = r_ff.rresp;
  assign sar_clk_pulse = tick & r_ff.conv_enable;
  assign sar_convert = r_ff.st == sacc_pkg::ST_CONV;
  assign sar_sample = r_ff.sample;
  assign conv_irq = r_ff.irq;
  // track window per mode
  assign track_en = r_ff.conv_enable & ~standby_req
    & (r_ff.tracking_mode_select
      ? (r_ff.st == sacc_pkg::ST_TRACK
        || (r_ff.st == sacc_pkg::ST_IDLE
          && r_ff.start_source_select == sacc_pkg::SRC_PIN && !r_ff.pin_s2))
      : r_ff.st != sacc_pkg::ST_CONV);
endmodule // sacc_top

// ==== sim/sacc_check_properties.sv ====
// protocol and timing checker for the conversion control block
`timescale 1ns/10ps
module sacc_check (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter side
  input wire logic standby_req,
  input wire logic track_en,
  input wire logic sar_convert
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_wr_resp_time: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_wr_ready_low: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_rd_single: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read answer repeated");
  a_no_track_standby: assert property (standby_req |-> !track_en)
    else $error("tracking in standby");
  a_no_track_conv: assert property (sar_convert |-> !track_en)
    else $error("tracking during conversion");
  a_conv_min_len: assert property ($rose(sar_convert) |->
    sar_convert[*8])
    else $error("conversion too short");
  a_conv_ends: assert property ($rose(sar_convert) |->
    ##[10:1000] !sar_convert)
    else $error("conversion never ends");
endmodule // sacc_check
bind sacc_top sacc_check u_sacc_check (.clk_sys(clk_sys), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .standby_req(standby_req),
  .track_en(track_en), .sar_convert(sar_convert));

// ==== sim/sacc_sar_model.sv ====
// behavioural analog core answering the control block
`timescale 1ns/10ps
module sacc_sar_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control side
  input wire logic sar_sample,
  input wire logic sar_convert,
  input wire logic [9:0] code_in,
  // result
  output logic [9:0] sar_code
);
  logic [9:0] held_ff;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      held_ff <= 10'h000;
    else if (sar_sample)
      held_ff <= code_in;
  // code only valid while converting, garbage otherwise
  assign sar_code = sar_convert ? held_ff : ~held_ff;
endmodule // sacc_sar_model

// ==== sim/tb_top.sv ====
// self-checking bench for the conversion control block
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [5:0] tmr = 6'h00;
  logic pin = 1'b0, stby = 1'b0;
  logic [9:0] code = 10'h000, sar_code;
  logic awready, wready, bvalid, arready, rvalid, sclk, trk, conv, smp, irq;
  logic [1:0] bresp, rresp, rs_q;
  logic [31:0] rdata, rd_q;
  int miscompares = 0, checked = 0, samples = 0;
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (smp) samples <= samples + 1;
  sacc_top u_sacc_top (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .tmr0_ovf(tmr[0]),
    .tmr1_ovf(tmr[1]), .tmr2_low_ovf(tmr[2]), .tmr2_high_ovf(tmr[3]),
    .tmr3_low_ovf(tmr[4]), .tmr3_high_ovf(tmr[5]),
    .external_start_pin(pin), .standby_req(stby), .sar_code(sar_code),
    .sar_clk_pulse(sclk), .track_en(trk), .sar_convert(conv),
    .sar_sample(smp), .conv_irq(irq));
  sacc_sar_model u_sacc_sar_model (.clk_sys(clk_sys), .reset(reset),
    .sar_sample(smp), .sar_convert(conv), .code_in(code),
    .sar_code(sar_code));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    give_verdict();
  endtask
  // handshakes judged on settled values before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    tb = 1'b0;
    for (i = 0; i < 200 && !tb; i++)
    begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!tb) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    tr = 1'b0;
    for (i = 0; i < 200 && !tr; i++)
    begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr)
      begin
        rd_q = rdata;
        rs_q = rresp;
      end
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
    end
    if (!tr) hang();
  endtask
  // completion polled on the flag, never on busy
  task automatic wait_flag();
    int i;
    rd_q = 32'h00000000;
    for (i = 0; i < 300 && !rd_q[5]; i++) rd(8'h00);
    if (!rd_q[5]) hang();
  endtask
  task automatic pulse(input int b);
    if (b == 6) pin <= 1'b1;
    else tmr[b] <= 1'b1;
    @(posedge clk_sys);
    pin <= 1'b0;
    tmr <= 6'h00;
    repeat (4) @(posedge clk_sys);
  endtask
  function automatic logic [15:0] fmt(logic [9:0] c, logic lj, logic df);
    if (lj) return {c, 6'h00};
    return df ? {{6{c[9]}}, c} : {6'h00, c};
  endfunction
  initial
  begin
    int k, s, n, good, bad;
    logic w;
    logic [9:0] corner [4];
    corner = '{10'h3FF, 10'h3FF, 10'h1FF, 10'h200};
    void'($urandom(16926));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h04);
    chk(rd_q, 32'hF8);
    rd(8'h10);
    chk(rs_q, 2'h2);
    wr(8'h00, 32'h10);
    repeat (40) @(posedge clk_sys);
    rd(8'h00);
    chk(rd_q, 32'h0);
    chk(32'(samples), 32'h0);
    wr(8'h00, 32'h80);
    for (k = 0; k < 12; k++)
    begin
      code <= (k < 4) ? corner[k] : 10'($urandom);
      stby <= 1'($urandom);
      wr(8'h04, {24'h0, 5'($urandom_range(0, 3)), k[0], 2'b00});
      wr(8'h0C, {30'h0, k[1], 1'b0});
      wr(8'h00, {24'h0, 1'b1, k[2], 6'h10});
      wait_flag();
      rd(8'h08);
      chk(rd_q, {16'h0, fmt(code, k[0], k[1])});
      rd(8'h00);
      chk(rd_q[5:4], 2'b10);
    end
    for (s = 1; s < 7; s++)
    begin
      w = 1'($urandom);
      wr(8'h0C, {28'h0, w, w, 1'b0, s != 3});
      wr(8'h00, 32'h80 | s);
      n = samples;
      good = (s == 2) ? 2 + w : (s == 5) ? 4 + w : (s == 4) ? 6
        : (s == 3) ? 1 : 0;
      bad = (s == 2) ? 3 - w : 5 - w;
      if (s == 2 || s == 5) pulse(bad);
      chk(32'(samples), 32'(n));
      pulse(good);
      pulse(good);
      if (s == 6) chk(32'(samples), 32'(n));
      else
      begin
        wait_flag();
        chk(32'(irq), 32'(s != 3));
        chk(32'(samples), 32'(n + 1));
      end
    end
    give_verdict();
  end
endmodule // tb_top
